// ===== common/dcf_pkg.sv
// Purpose: Shared constants and helpers for the dual-clock flagged FIFO.
// Assumes: One write domain (core_clk) and one read domain (read_clk).
// Notes:   Offsets are AW bits wide; the first parallel write of an offset carries the low half.
package dcf_pkg;

  localparam int DCF_DEPTH  = 524288;  // Memory words in standard mode
  localparam int DCF_DATA_W = 36;      // Word width
  localparam int DCF_HALF_W = 10;      // Offset bits carried by the first parallel write
  localparam int DCF_DEF_W  = 11;      // Width of the preset offset table entries

  // Boot settle count: straps pass a two-stage synchroniser first
  localparam logic [1:0] DCF_BOOT_CAP = 2'h2;

  // Parallel offset access order
  localparam logic [1:0] DCF_SLOT_EMPTY_LO = 2'h0;
  localparam logic [1:0] DCF_SLOT_EMPTY_HI = 2'h1;
  localparam logic [1:0] DCF_SLOT_FULL_LO  = 2'h2;
  localparam logic [1:0] DCF_SLOT_FULL_HI  = 2'h3;

  typedef enum {DCF_BOOT_SETTLE, DCF_BOOT_RUN} dcf_boot_t;

  // Preset offset, selected by {load, select1, select0} at master reset
  function automatic logic [DCF_DEF_W-1:0] dcf_default_ofs(input logic [2:0] sel);
    case (sel)
      3'h4:    return 11'h3FF;
      3'h2:    return 11'h1FF;
      3'h1:    return 11'h0FF;
      3'h0:    return 11'h07F;
      3'h3:    return 11'h03F;
      3'h6:    return 11'h01F;
      3'h5:    return 11'h00F;
      default: return 11'h007;
    endcase
  endfunction

endpackage

// ===== common/dcf_mem_if.sv
// Purpose: Carries the write and read ports of the FIFO storage array.
// Assumes: Writes on the write clock; reads are combinational from a stable address.
// Notes:   The top module drives the owner side directly.
`timescale 1ns/1ns
interface dcf_mem_if #(parameter int AW = 19, parameter int DW = 36) ();
  logic          wr_en;
  logic [AW-1:0] wr_addr;
  logic [DW-1:0] wr_data;
  logic [AW-1:0] rd_addr;
  logic [DW-1:0] rd_data;

  modport owner (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
  modport ram   (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// ===== rtl/dcf_sync.sv
// Purpose: Two-stage synchroniser for levels and Gray-coded words.
// Assumes: Each bit may change at most once per destination sample.
// Notes:   Stage one is read only by stage two.
`timescale 1ns/1ns
module dcf_sync #(parameter int W = 1) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] stage1_ff;
  logic [W-1:0] stage2_ff;

  // Double flop into the destination domain
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      stage1_ff <= '0;
      stage2_ff <= '0;
    end else begin
      stage1_ff <= d;
      stage2_ff <= stage1_ff;
    end
  end

  assign q = stage2_ff;
endmodule

// ===== rtl/dcf_mem.sv
// Purpose: FIFO word storage, written on the write clock.
// Assumes: A read address only points at words written several cycles earlier.
// Notes:   Read is combinational; the caller registers the result.
`timescale 1ns/1ns
module dcf_mem #(parameter int AW = 19, parameter int DW = 36) (
  input  wire logic clk,
  dcf_mem_if.ram    mem
);
  logic [DW-1:0] store [2**AW];

  // Write port
  always_ff @(posedge clk) begin
    if (mem.wr_en) begin
      store[mem.wr_addr] <= mem.wr_data;
    end
  end

  // Read port
  assign mem.rd_data = store[mem.rd_addr];
endmodule

// ===== rtl/dcf_fifo.sv
// Purpose: Dual-clock FIFO with standard and fall-through timing and offset flags.
// Assumes: core_clk is the write clock, read_clk the read clock; rstn is master reset.
// Notes:   Straps must stay steady for three core_clk edges after rstn rises.
// Summary of operation
// - Fall-through select sampled at master reset
// - Fall-through: first word shown after three edges
// - Write enable low captures data each edge
// - Standard: empty flag rises after first write
// - Standard: almost-empty high above n words
// - Almost-full low when free space reaches m
// - Standard: full after D words, blocks writes
// - Standard: empty after last read, reads ignored
// - Standard empty/full flags double registered
// - Fall-through: output ready low when word shown
// - Fall-through: almost-empty high above n+1 words
// - Fall-through: input ready high at D+1 words
// - Fall-through: output ready high when drained
// - Output ready three stages, input ready two (code: output ready falls on the same read_clk edge as the empty flag would)
// - Preset offset pair loaded at master reset
// - Load pin at reset picks serial/parallel
// - Offsets read back only on data outputs
// - Offsets programmable any time, within 0..D-1
// - Standard depth is 524,288 words
// - Serial load: 38 bits, empty LSB first
// - Parallel load: four writes, empty then full
`timescale 1ns/1ns
module dcf_fifo
  import dcf_pkg::*;
#(
  parameter int DEPTH = DCF_DEPTH,
  parameter int DW    = DCF_DATA_W
) (
  input  wire logic          core_clk,
  input  wire logic          rstn,
  input  wire logic          read_clk,
  input  wire logic          write_enable_n,
  input  wire logic [DW-1:0] write_data,
  input  wire logic          read_enable_n,
  input  wire logic          offset_load_n,
  input  wire logic          fall_through_select_serial_in,
  input  wire logic          default_offset_select0,
  input  wire logic          default_offset_select1,
  input  wire logic          serial_clk,
  input  wire logic          serial_load_enable_n,
  output logic      [DW-1:0] read_data,
  output logic               empty_flag_n,
  output logic               output_ready_n,
  output logic               full_flag_n,
  output logic               input_ready_n,
  output logic               almost_empty_flag_n,
  output logic               almost_full_flag_n
);
  localparam int AW    = $clog2(DEPTH);
  localparam int PW    = AW + 1;
  localparam int HI_W  = AW - DCF_HALF_W;
  localparam int SER_W = 2 * AW;
  localparam int SC_W  = $clog2(SER_W);
  localparam logic [PW-1:0]   ONE      = PW'(1);
  localparam logic [PW-1:0]   TWO      = PW'(2);
  localparam logic [PW-1:0]   CAP_STD  = PW'(DEPTH);
  localparam logic [PW-1:0]   CAP_FT   = PW'(DEPTH + 1);
  localparam logic [SC_W-1:0] SER_LAST = SC_W'(SER_W - 1);

  // Refuse sizes the offset slicing and pointers cannot serve
  if ((1 << AW) != DEPTH || AW < DCF_DEF_W || HI_W > DCF_HALF_W || DW < DCF_HALF_W) begin : g_bad_size
    $error("dcf_fifo: DEPTH must be a power of two from 2048 to 2**20 and DW at least 10");
  end

  function automatic logic [PW-1:0] to_gray(input logic [PW-1:0] b);
    return b ^ (b >> 1);
  endfunction

  function automatic logic [PW-1:0] from_gray(input logic [PW-1:0] g);
    logic [PW-1:0] b;
    b = g;
    for (int i = PW - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    return b;
  endfunction

  // Zero-extended offset slice for readback on the data outputs
  function automatic logic [DW-1:0] ofs_chunk(input logic [1:0] slot, input logic [AW-1:0] e,
                                              input logic [AW-1:0] f);
    case (slot)
      DCF_SLOT_EMPTY_LO: return DW'(e[DCF_HALF_W-1:0]);
      DCF_SLOT_EMPTY_HI: return DW'(e[AW-1:DCF_HALF_W]);
      DCF_SLOT_FULL_LO:  return DW'(f[DCF_HALF_W-1:0]);
      default:           return DW'(f[AW-1:DCF_HALF_W]);
    endcase
  endfunction

  // ---------------- Write domain ----------------
  logic [4:0]      pin_s;
  logic [PW-1:0]   cptr_gray_w;
  logic [PW-1:0]   cptr_gray_ff;
  dcf_boot_t       boot_state_ff;
  logic [1:0]      boot_cnt_ff;
  logic            fall_through_mode_ff;
  logic            ser_mode_ff;
  logic [PW-1:0]   wptr_ff;
  logic [PW-1:0]   wptr_gray_ff;
  logic [AW-1:0]   empty_ofs_ff;
  logic [AW-1:0]   full_ofs_ff;
  logic            ofs_tgl_ff;
  logic [1:0]      par_slot_ff;
  logic            sclk_prev_ff;
  logic [SER_W-1:0] ser_sr_ff;
  logic [SC_W-1:0] ser_cnt_ff;
  logic            full_flag_n_ff;
  logic            input_ready_n_ff;
  logic            almost_full_flag_n_ff;

  dcf_mem_if #(.AW(AW), .DW(DW)) mem_bus ();

  dcf_mem #(.AW(AW), .DW(DW)) u_mem (
    .clk (core_clk),
    .mem (mem_bus.ram)
  );

  dcf_sync #(.W(5)) u_pin_sync (
    .clk  (core_clk),
    .rstn (rstn),
    .d    ({fall_through_select_serial_in, serial_clk, serial_load_enable_n,
            default_offset_select1, default_offset_select0}),
    .q    (pin_s)
  );

  dcf_sync #(.W(PW)) u_cptr_sync (
    .clk  (core_clk),
    .rstn (rstn),
    .d    (cptr_gray_ff),
    .q    (cptr_gray_w)
  );

  wire             si_s      = pin_s[4];
  wire             sclk_s    = pin_s[3];
  wire             sen_n_s   = pin_s[2];
  wire [1:0]       fsel_s    = pin_s[1:0];
  wire             boot_done = (boot_state_ff == DCF_BOOT_RUN);
  wire             boot_cap  = (boot_state_ff == DCF_BOOT_SETTLE) && (boot_cnt_ff == DCF_BOOT_CAP);
  wire [AW-1:0]    def_ofs   = AW'(dcf_default_ofs({offset_load_n, fsel_s}));

  // Fill accounting against the delivered-word pointer of the read side
  wire [PW-1:0]    cptr_w    = from_gray(cptr_gray_w);
  wire [PW-1:0]    wr_total  = wptr_ff - cptr_w;
  wire [PW-1:0]    cap_w     = fall_through_mode_ff ? CAP_FT : CAP_STD;
  wire             full_now  = (wr_total >= cap_w);
  wire             wr_accept = boot_done && offset_load_n && !write_enable_n && !full_now;
  wire [PW-1:0]    nxt_wptr  = wptr_ff + (wr_accept ? ONE : '0);
  wire [PW-1:0]    nxt_total = nxt_wptr - cptr_w;
  wire             nxt_full  = (nxt_total >= cap_w);
  wire             nxt_af_n  = (nxt_total < (cap_w - {1'b0, full_ofs_ff}));

  wire             par_wr     = boot_done && !ser_mode_ff && !offset_load_n && !write_enable_n;
  // serial shift on synchronised clock edges
  wire             ser_shift  = boot_done && ser_mode_ff && !offset_load_n && !sen_n_s && sclk_s && !sclk_prev_ff;
  wire [SER_W-1:0] nxt_ser_sr = {si_s, ser_sr_ff[SER_W-1:1]};
  wire             ser_commit = ser_shift && (ser_cnt_ff == SER_LAST);
  // One toggle per complete offset set, so back-to-back loads cannot cancel in the read-side sync
  wire             ofs_upd    = boot_cap || ser_commit || (par_wr && par_slot_ff == DCF_SLOT_FULL_HI);

  wire [AW-1:0] nxt_empty_ofs =
      boot_cap ? def_ofs :
      (par_wr && par_slot_ff == DCF_SLOT_EMPTY_LO) ? {empty_ofs_ff[AW-1:DCF_HALF_W], write_data[DCF_HALF_W-1:0]} :
      (par_wr && par_slot_ff == DCF_SLOT_EMPTY_HI) ? {write_data[HI_W-1:0], empty_ofs_ff[DCF_HALF_W-1:0]} :
      ser_commit ? nxt_ser_sr[AW-1:0] : empty_ofs_ff;
  wire [AW-1:0] nxt_full_ofs =
      boot_cap ? def_ofs :
      (par_wr && par_slot_ff == DCF_SLOT_FULL_LO) ? {full_ofs_ff[AW-1:DCF_HALF_W], write_data[DCF_HALF_W-1:0]} :
      (par_wr && par_slot_ff == DCF_SLOT_FULL_HI) ? {write_data[HI_W-1:0], full_ofs_ff[DCF_HALF_W-1:0]} :
      ser_commit ? nxt_ser_sr[SER_W-1:AW] : full_ofs_ff;

  assign mem_bus.wr_en   = wr_accept;
  assign mem_bus.wr_addr = wptr_ff[AW-1:0];
  assign mem_bus.wr_data = write_data;

  // strap capture after the synchroniser settles
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      boot_state_ff <= DCF_BOOT_SETTLE;
      boot_cnt_ff   <= '0;
      fall_through_mode_ff       <= 1'b0;
      ser_mode_ff   <= 1'b0;
    end else begin
      case (boot_state_ff)
        DCF_BOOT_SETTLE: begin
          boot_cnt_ff <= boot_cnt_ff + 2'h1;
          if (boot_cap) begin
            fall_through_mode_ff       <= si_s;
            ser_mode_ff   <= offset_load_n;
            boot_state_ff <= DCF_BOOT_RUN;
          end
        end
        DCF_BOOT_RUN: boot_state_ff <= DCF_BOOT_RUN;
        default:      boot_state_ff <= DCF_BOOT_SETTLE;
      endcase
    end
  end

  // Write pointer and write-side flags
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wptr_ff               <= '0;
      wptr_gray_ff          <= '0;
      full_flag_n_ff        <= 1'b1;
      input_ready_n_ff      <= 1'b0;
      almost_full_flag_n_ff <= 1'b1;
    end else begin
      wptr_ff               <= nxt_wptr;
      wptr_gray_ff          <= to_gray(nxt_wptr);
      full_flag_n_ff        <= !nxt_full;
      input_ready_n_ff      <= nxt_full;
      almost_full_flag_n_ff <= nxt_af_n;
    end
  end

  // Offset registers and their programming sequencers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      empty_ofs_ff <= '0;
      full_ofs_ff  <= '0;
      ofs_tgl_ff   <= 1'b0;
      par_slot_ff  <= DCF_SLOT_EMPTY_LO;
      sclk_prev_ff <= 1'b0;
      ser_sr_ff    <= '0;
      ser_cnt_ff   <= '0;
    end else begin
      empty_ofs_ff <= nxt_empty_ofs;
      full_ofs_ff  <= nxt_full_ofs;
      ofs_tgl_ff   <= ofs_tgl_ff ^ ofs_upd;
      par_slot_ff  <= offset_load_n ? DCF_SLOT_EMPTY_LO : par_slot_ff + (par_wr ? 2'h1 : 2'h0);
      sclk_prev_ff <= sclk_s;
      if (ser_shift) begin
        ser_sr_ff  <= nxt_ser_sr;
        ser_cnt_ff <= ser_commit ? '0 : ser_cnt_ff + SC_W'(1);
      end
    end
  end

  // ---------------- Read domain ----------------
  logic            rd_rstn;
  logic [PW-1:0]   wptr_gray_r;
  logic [3:0]      lvl_r;
  logic [PW-1:0]   rptr_ff;
  logic            ov_ff;
  logic            tgl_prev_ff;
  logic [AW-1:0]   empty_ofs_r_ff;
  logic [AW-1:0]   full_ofs_r_ff;
  logic [1:0]      rd_slot_ff;
  logic [DW-1:0]   q_ff;
  logic            empty_flag_n_ff;
  logic            output_ready_n_ff;
  logic            almost_empty_flag_n_ff;

  dcf_sync #(.W(1)) u_rd_rst (
    .clk  (read_clk),
    .rstn (rstn),
    .d    (1'b1),
    .q    (rd_rstn)
  );

  dcf_sync #(.W(PW)) u_wptr_sync (
    .clk  (read_clk),
    .rstn (rd_rstn),
    .d    (wptr_gray_ff),
    .q    (wptr_gray_r)
  );

  dcf_sync #(.W(4)) u_lvl_sync (
    .clk  (read_clk),
    .rstn (rd_rstn),
    .d    ({boot_done, fall_through_mode_ff, offset_load_n, ofs_tgl_ff}),
    .q    (lvl_r)
  );

  wire           rd_live  = lvl_r[3];
  wire           fall_through_mode_r   = lvl_r[2];
  wire           ld_r     = lvl_r[1];
  wire           ofs_take = lvl_r[0] ^ tgl_prev_ff;
  wire [PW-1:0]  wptr_r   = from_gray(wptr_gray_r);
  wire           rd_empty_now = (rptr_ff == wptr_r);
  wire           rd_req   = rd_live && ld_r && !read_enable_n;
  wire           std_read = !fall_through_mode_r && rd_req && !rd_empty_now;
  // fall-through prefetch into the output register
  wire           ft_pop   = fall_through_mode_r && rd_req && ov_ff;
  wire           ft_load  = fall_through_mode_r && rd_live && !rd_empty_now && (!ov_ff || ft_pop);
  wire           mem_rd   = std_read || ft_load;
  wire [PW-1:0]  nxt_rptr = rptr_ff + (mem_rd ? ONE : '0);
  wire           nxt_ov   = ft_load || (ov_ff && !ft_pop);
  wire [PW-1:0]  nxt_cptr = nxt_rptr - PW'(nxt_ov);
  wire [PW-1:0]  rd_fill  = wptr_r - nxt_cptr;
  wire [PW-1:0]  ae_thr   = {1'b0, empty_ofs_r_ff} + (fall_through_mode_r ? TWO : ONE);
  // offset readback only on the data outputs
  wire           ofs_rd   = rd_live && !ld_r && !read_enable_n;

  assign mem_bus.rd_addr = rptr_ff[AW-1:0];

  // Read pointer, output register and read-side flags
  always_ff @(posedge read_clk or negedge rd_rstn) begin
    if (!rd_rstn) begin
      rptr_ff                <= '0;
      cptr_gray_ff           <= '0;
      ov_ff                  <= 1'b0;
      empty_flag_n_ff        <= 1'b0;
      output_ready_n_ff      <= 1'b1;
      almost_empty_flag_n_ff <= 1'b0;
    end else begin
      rptr_ff                <= nxt_rptr;
      cptr_gray_ff           <= to_gray(nxt_cptr);
      ov_ff                  <= nxt_ov;
      empty_flag_n_ff        <= (nxt_rptr != wptr_r);
      output_ready_n_ff      <= !nxt_ov;
      almost_empty_flag_n_ff <= (rd_fill >= ae_thr);
    end
  end

  // Data outputs and offset copy; the copy is taken on a settled toggle
  always_ff @(posedge read_clk or negedge rd_rstn) begin
    if (!rd_rstn) begin
      q_ff           <= '0;
      tgl_prev_ff    <= 1'b0;
      empty_ofs_r_ff <= '0;
      full_ofs_r_ff  <= '0;
      rd_slot_ff     <= DCF_SLOT_EMPTY_LO;
    end else begin
      tgl_prev_ff <= lvl_r[0];
      if (ofs_take) begin
        empty_ofs_r_ff <= empty_ofs_ff;
        full_ofs_r_ff  <= full_ofs_ff;
      end
      rd_slot_ff <= ld_r ? DCF_SLOT_EMPTY_LO : rd_slot_ff + (ofs_rd ? 2'h1 : 2'h0);
      if (ofs_rd) begin
        q_ff <= ofs_chunk(rd_slot_ff, empty_ofs_r_ff, full_ofs_r_ff);
      end else if (mem_rd) begin
        q_ff <= mem_bus.rd_data;
      end
    end
  end

  assign read_data           = q_ff;
  assign empty_flag_n        = empty_flag_n_ff;
  assign output_ready_n      = output_ready_n_ff;
  assign full_flag_n         = full_flag_n_ff;
  assign input_ready_n       = input_ready_n_ff;
  assign almost_empty_flag_n = almost_empty_flag_n_ff;
  assign almost_full_flag_n  = almost_full_flag_n_ff;

  // ---------------- Checks ----------------
  sequence s_ft_waiting;
    fall_through_mode_r && rd_live && !ov_ff && !rd_empty_now;
  endsequence
  sequence s_ft_shown;
    ov_ff && !output_ready_n_ff && (rptr_ff == $past(rptr_ff) + ONE);
  endsequence

  property p_strap;
    @(posedge core_clk) disable iff (!rstn)
      boot_cap |=> fall_through_mode_ff == $past(si_s) && ser_mode_ff == $past(offset_load_n) && empty_ofs_ff == $past(def_ofs);
  endproperty
  a_strap: assert property (p_strap) else $error("strap or preset offset not captured");

  property p_full_stall;
    @(posedge core_clk) disable iff (!rstn) full_now |=> wptr_ff == $past(wptr_ff);
  endproperty
  a_full_stall: assert property (p_full_stall) else $error("write taken while full");

  property p_full_flag;
    @(posedge core_clk) disable iff (!rstn)
      !fall_through_mode_ff && boot_done ##1 $stable(cptr_w) |-> full_flag_n_ff == (wr_total < CAP_STD);
  endproperty
  a_full_flag: assert property (p_full_flag) else $error("full flag disagrees with fill");

  property p_ir_flag;
    @(posedge core_clk) disable iff (!rstn)
      fall_through_mode_ff && boot_done ##1 $stable(cptr_w) |-> input_ready_n_ff == (wr_total >= CAP_FT);
  endproperty
  a_ir_flag: assert property (p_ir_flag) else $error("input ready disagrees with fill");

  property p_af_flag;
    @(posedge core_clk) disable iff (!rstn)
      boot_done ##1 $stable(cptr_w) && $stable(full_ofs_ff)
      |-> almost_full_flag_n_ff == (wr_total < cap_w - {1'b0, full_ofs_ff});
  endproperty
  a_af_flag: assert property (p_af_flag) else $error("almost-full disagrees with fill");

  property p_par_full_hi;
    @(posedge core_clk) disable iff (!rstn)
      par_wr && par_slot_ff == DCF_SLOT_FULL_HI |=> full_ofs_ff[AW-1:DCF_HALF_W] == $past(write_data[HI_W-1:0]);
  endproperty
  a_par_full_hi: assert property (p_par_full_hi) else $error("full offset high part not loaded");

  property p_ft_first;
    @(posedge read_clk) disable iff (!rd_rstn) s_ft_waiting |=> s_ft_shown;
  endproperty
  a_ft_first: assert property (p_ft_first) else $error("waiting word not shown");

  property p_ft_drain;
    @(posedge read_clk) disable iff (!rd_rstn)
      ft_pop && rd_empty_now |=> !ov_ff && output_ready_n_ff;
  endproperty
  a_ft_drain: assert property (p_ft_drain) else $error("output ready stays low after last read");

  property p_std_empty;
    @(posedge read_clk) disable iff (!rd_rstn)
      !fall_through_mode_r && rd_empty_now |=> rptr_ff == $past(rptr_ff);
  endproperty
  a_std_empty: assert property (p_std_empty) else $error("read taken while empty");

  property p_ae_std;
    @(posedge read_clk) disable iff (!rd_rstn)
      !fall_through_mode_r && rd_live ##1 $stable(wptr_r) && $stable(empty_ofs_r_ff)
      |-> almost_empty_flag_n_ff == ((wptr_r - rptr_ff) > {1'b0, empty_ofs_r_ff});
  endproperty
  a_ae_std: assert property (p_ae_std) else $error("almost-empty disagrees with fill");
endmodule

// ===== tb/dcf_reader.sv
// Purpose: Read-side consumer model for the dual-clock FIFO.
// Assumes: budget only grows between resets.
// Notes:   fall_through_mode picks the flag that marks a word as ready.
`timescale 1ns/1ns
module dcf_reader (
  read_clk,
  rstn,
  fall_through_mode,
  empty_flag_n,
  output_ready_n,
  budget,
  read_enable_n,
  taken_ff
);
  input  wire logic read_clk;
  input  wire logic rstn;
  input  wire logic fall_through_mode;
  input  wire logic empty_flag_n;
  input  wire logic output_ready_n;
  input  int        budget;
  output logic      read_enable_n;
  output int        taken_ff;

  logic ren_n_ff;
  int   nxt_taken;

  // A word is taken when the request meets a ready flag
  assign nxt_taken     = taken_ff + int'(!ren_n_ff && (fall_through_mode ? !output_ready_n : empty_flag_n));
  assign read_enable_n = ren_n_ff;

  always_ff @(posedge read_clk or negedge rstn) begin
    if (!rstn) begin
      taken_ff <= 0;
      ren_n_ff <= 1'b1;
    end else begin
      taken_ff <= nxt_taken;
      ren_n_ff <= !(nxt_taken < budget);
    end
  end
endmodule

// ===== tb/dcf_fifo_test.sv
// Purpose: Self-checking bench for the dual-clock flagged FIFO.
// Assumes: Depth 2048; preset offsets n = m = 1023 with serial strap.
// Notes:   Writes on core_clk, reads through the consumer model.
`timescale 1ns/1ns
module dcf_fifo_test;
  import dcf_pkg::*;

  logic          core_clk = 1'b0;
  logic          read_clk = 1'b0;
  logic          rstn = 1'b0;
  logic          write_enable_n = 1'b1;
  logic [35:0]   write_data = 36'h0;
  logic          offset_load_n = 1'b1;
  logic          ft_sel = 1'b0;
  logic [35:0]   read_data;
  logic          read_enable_n, empty_flag_n, output_ready_n, full_flag_n;
  logic          input_ready_n, almost_empty_flag_n, almost_full_flag_n;
  int            budget = 0;
  int            taken, wcnt, failures, num_checks, cyc;

  dcf_fifo #(.DEPTH(2048)) dcf_fifo_inst (.core_clk(core_clk), .rstn(rstn), .read_clk(read_clk),
    .write_enable_n(write_enable_n), .write_data(write_data), .read_enable_n(read_enable_n),
    .offset_load_n(offset_load_n), .fall_through_select_serial_in(ft_sel),
    .default_offset_select0(1'b0), .default_offset_select1(1'b0), .serial_clk(1'b0),
    .serial_load_enable_n(1'b1), .read_data(read_data), .empty_flag_n(empty_flag_n),
    .output_ready_n(output_ready_n), .full_flag_n(full_flag_n), .input_ready_n(input_ready_n),
    .almost_empty_flag_n(almost_empty_flag_n), .almost_full_flag_n(almost_full_flag_n));

  dcf_reader dcf_reader_inst (.read_clk(read_clk), .rstn(rstn), .fall_through_mode(ft_sel), .empty_flag_n(empty_flag_n),
    .output_ready_n(output_ready_n), .budget(budget), .read_enable_n(read_enable_n), .taken_ff(taken));

  // Clocks with unrelated phases
  initial begin
    forever #2 core_clk = ~core_clk;
  end
  initial begin
    #7;
    forever #15 read_clk = ~read_clk;
  end

  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic results();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Straps held through boot, then a settle time for the read side
  task automatic reset(input logic ft, input logic ld);
    @(posedge core_clk);
    rstn <= 1'b0;
    ft_sel <= ft;
    offset_load_n <= ld;
    budget <= 0;
    wcnt = 0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (80) @(posedge core_clk);
  endtask

  task automatic wr(input int n, input int settle);
    repeat (n) begin
      @(posedge core_clk);
      write_enable_n <= 1'b0;
      write_data <= 36'(wcnt);
      wcnt++;
    end
    @(posedge core_clk);
    write_enable_n <= 1'b1;
    repeat (settle) @(posedge core_clk);
  endtask

  task automatic rd(input int n);
    budget <= budget + n;
    @(posedge core_clk);
    for (int k = 0; k < 400 && taken != budget; k++) @(posedge core_clk);
    repeat (30) @(posedge core_clk);
    check(36'(taken), 36'(budget));
  endtask

  task automatic t_std_basic();
    check(empty_flag_n, 1'b0);
    wr(1, 30);
    check(empty_flag_n, 1'b1);
    rd(1);
    check(read_data, 36'h0);
    check(empty_flag_n, 1'b0);
  endtask

  task automatic t_std_fill();
    wr(1023, 30);
    check(almost_empty_flag_n, 1'b0);
    wr(1, 30);
    check(almost_empty_flag_n, 1'b1);
    check(almost_full_flag_n, 1'b1);
    wr(1, 30);
    check(almost_full_flag_n, 1'b0);
    wr(1022, 30);
    check(full_flag_n, 1'b1);
    wr(2, 30);
    check(full_flag_n, 1'b0);
    check(input_ready_n, 1'b1);
    rd(1);
    check(read_data, 36'h1);
    check(full_flag_n, 1'b1);
  endtask

  task automatic t_fall_through_mode();
    wr(1, 0);
    check(output_ready_n, 1'b1);
    repeat (40) @(posedge core_clk);
    check(output_ready_n, 1'b0);
    check(read_data, 36'h0);
    rd(1);
    check(output_ready_n, 1'b1);
  endtask

  task automatic t_parallel();
    for (int i = 0; i < 4; i++) begin
      @(posedge core_clk);
      write_enable_n <= 1'b0;
      write_data <= i[0] ? 36'h0 : 36'h5;
    end
    @(posedge core_clk);
    write_enable_n <= 1'b1;
    offset_load_n <= 1'b1;
    repeat (40) @(posedge core_clk);
    wr(5, 30);
    check(almost_empty_flag_n, 1'b0);
    wr(1, 30);
    check(almost_empty_flag_n, 1'b1);
  endtask

  // Run ceiling
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      results();
    end
  end

  initial begin
    reset(1'b0, 1'b1);
    t_std_basic();
    t_std_fill();
    reset(1'b1, 1'b1);
    t_fall_through_mode();
    reset(1'b0, 1'b0);
    t_parallel();
    results();
  end
endmodule
